// ===== rtl/dma_channel_irq_enable_group4.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_group4_map.svh"

module dma_channel_irq_enable_group4
  import irq_group4_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Completion pulses from the DMA channels, same clock
  input  wire logic [3:0]  done_b_anc,
  input  wire logic [15:0] done_a_anc,
  input  wire logic [11:0] done_b_vid,
  // Shared interrupt line
  output logic             dma_irq_line_one
);

  // Offset decode, shared by read and write paths
  function automatic reg_sel_t decode(input logic [7:0] a);
    if (a == `IRQ_ENABLE_OFFSET)
      return sel_enable;
    else if (a == `IRQ_STATUS_OFFSET)
      return sel_status;
    else
      return sel_none;
  endfunction

  // Pending test, shared by the line logic and its checks
  function automatic logic pending(input word_t flags, input word_t enables);
    return |(flags & enables);
  endfunction

  word_t       enable_q;
  word_t       enable_d;
  word_t       status_q;
  word_t       status_d;
  word_t       events;
  logic [31:0] rdata_d;
  logic        irq_d;
  reg_sel_t    sel;
  logic        wr_enable;
  logic        wr_status;
  logic        rd_enable;
  logic        rd_status;

  // Pack events into the register layout; status and enable share this map
  always_comb
  begin
    events = '0;
    events[`FLD_B_ANC_MSB:`FLD_B_ANC_LSB] = done_b_anc;
    events[`FLD_A_ANC_MSB:`FLD_A_ANC_LSB] = done_a_anc;
    events[`FLD_B_VID_MSB:`FLD_B_VID_LSB] = done_b_vid;
  end

  // Access decode, done once so every group sees the same hit
  always_comb
  begin
    sel = decode(addr);
    wr_enable = wr && (sel == sel_enable);
    wr_status = wr && (sel == sel_status);
    rd_enable = rd && (sel == sel_enable);
    rd_status = rd && (sel == sel_status);
  end

  // Enable group: software owns every bit, hardware never changes one
  always_comb
  begin
    enable_d = enable_q;
    if (wr_enable)
      enable_d = wdata;
  end

  // Enable register; zero after reset keeps every event off the line
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      enable_q <= `IRQ_ENABLE_RESET;
    else
      enable_q <= enable_d;
  end

  // Status group: clear first, then set, so an event in the clear cycle survives
  always_comb
  begin
    status_d = status_q;
    if (wr_status)
      status_d = status_q & ~wdata;
    status_d = status_d | events;
  end

  // Status register; a bit only leaves by a software clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_q <= `IRQ_STATUS_RESET;
    else
      status_q <= status_d;
  end

  // Read group: data stands one cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_d = 32'h0000_0000;                             // Unmapped reads give zero
    if (rd_enable)
      rdata_d = enable_q;
    else if (rd_status)
      rdata_d = status_q;
  end

  // Read data register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else
      rdata <= rdata_d;
  end

  // Line from the next register values, so a new event or a new enable
  // shows one edge later, with no extra cycle of lag
  always_comb
  begin
    irq_d = pending(status_d, enable_d);
  end

  // Registered so the line has no glitch from decode logic
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dma_irq_line_one <= 1'h0;
    else
      dma_irq_line_one <= irq_d;
  end

  // Checks
  property p_irq_level;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> dma_irq_line_one == |(status_q & enable_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not status and enable");

  property p_masked_quiet;
    @(posedge clk) disable iff (!rstn)
      (enable_q == 32'h0000_0000) |-> !dma_irq_line_one;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq with all disabled");

  property p_event_fires;
    @(posedge clk) disable iff (!rstn)
      (|(events & enable_q) && !(wr && decode(addr) == sel_enable)) |=> dma_irq_line_one;
  endproperty
  a_event_fires: assert property (p_event_fires) else $error("enabled event missed");

  property p_sticky;
    @(posedge clk) disable iff (!rstn)
      (status_q != 32'h0 && !wr_status)
        |=> (status_q & $past(status_q)) == $past(status_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost without clear");

  property p_set_on_event;
    @(posedge clk) disable iff (!rstn)
      events[31] |=> status_q[31];
  endproperty
  a_set_on_event: assert property (p_set_on_event) else $error("b anc ch3 not set");

  property p_a_anc_map;
    @(posedge clk) disable iff (!rstn)
      done_a_anc[0] |=> status_q[12];
  endproperty
  a_a_anc_map: assert property (p_a_anc_map) else $error("a anc ch0 not at bit 12");

  property p_b_vid_map;
    @(posedge clk) disable iff (!rstn)
      done_b_vid[11] |=> status_q[11];
  endproperty
  a_b_vid_map: assert property (p_b_vid_map) else $error("b vid ch15 not at bit 11");

  property p_w1c;
    @(posedge clk) disable iff (!rstn)
      (wr && decode(addr) == sel_status && wdata[0] && !events[0]) |=> !status_q[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_enable_rw;
    @(posedge clk) disable iff (!rstn)
      (wr && decode(addr) == sel_enable) ##1 (rd && decode(addr) == sel_enable)
        |=> rdata == $past(enable_q);
  endproperty
  a_enable_rw: assert property (p_enable_rw) else $error("enable readback wrong");

  // Reset values, register access, further field positions and line behaviour
  property p_reset_values;
    @(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> enable_q == `IRQ_ENABLE_RESET && status_q == `IRQ_STATUS_RESET
        && !dma_irq_line_one && rdata == 32'h0000_0000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_unmapped_read;
    @(posedge clk) disable iff (!rstn)
      (rd && decode(addr) == sel_none) |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_status_read;
    @(posedge clk) disable iff (!rstn)
      rd_status |=> rdata == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_enable_hold;
    @(posedge clk) disable iff (!rstn)
      !wr_enable |=> $stable(enable_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable moved without write");

  property p_enable_load;
    @(posedge clk) disable iff (!rstn)
      wr_enable |=> enable_q == $past(wdata);
  endproperty
  a_enable_load: assert property (p_enable_load) else $error("enable write lost");

  property p_b_anc_ch0;
    @(posedge clk) disable iff (!rstn)
      done_b_anc[0] |=> status_q[28];
  endproperty
  a_b_anc_ch0: assert property (p_b_anc_ch0) else $error("b anc ch0 not at bit 28");

  property p_a_anc_ch15;
    @(posedge clk) disable iff (!rstn)
      done_a_anc[15] |=> status_q[27];
  endproperty
  a_a_anc_ch15: assert property (p_a_anc_ch15) else $error("a anc ch15 not at bit 27");

  property p_a_anc_ch8;
    @(posedge clk) disable iff (!rstn)
      done_a_anc[8] |=> status_q[20];
  endproperty
  a_a_anc_ch8: assert property (p_a_anc_ch8) else $error("a anc ch8 not at bit 20");

  property p_b_vid_ch4;
    @(posedge clk) disable iff (!rstn)
      done_b_vid[0] |=> status_q[0];
  endproperty
  a_b_vid_ch4: assert property (p_b_vid_ch4) else $error("b vid ch4 not at bit 0");

  property p_zero_keeps;
    @(posedge clk) disable iff (!rstn)
      (wr_status && !wdata[31] && status_q[31]) |=> status_q[31];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("write zero cleared a flag");

  property p_set_wins;
    @(posedge clk) disable iff (!rstn)
      (wr_status && wdata[12] && events[12]) |=> status_q[12];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to same cycle clear");

  property p_line_drops;
    @(posedge clk) disable iff (!rstn)
      (wr_status && (wdata & status_q & enable_q) == (status_q & enable_q)
        && !pending(events, enable_q)) |=> !dma_irq_line_one;
  endproperty
  a_line_drops: assert property (p_line_drops) else $error("line held after clear");

  property p_masked_blocks;
    @(posedge clk) disable iff (!rstn)
      (!pending(status_q, enable_q) && !pending(events, enable_q) && !wr_enable)
        |=> !dma_irq_line_one;
  endproperty
  a_masked_blocks: assert property (p_masked_blocks) else $error("masked flag raised line");

  c_irq_rise: cover property (@(posedge clk) disable iff (!rstn) $rose(dma_irq_line_one));
  c_masked_event: cover property (@(posedge clk) disable iff (!rstn)
    |(events & ~enable_q) && !dma_irq_line_one);
  c_clear_irq: cover property (@(posedge clk) disable iff (!rstn) $fell(dma_irq_line_one));
  c_set_clear_same: cover property (@(posedge clk) disable iff (!rstn)
    wr && decode(addr) == sel_status && |(wdata & events));

endmodule
`default_nettype wire

// ===== rtl/irq_group4_map.svh
`ifndef IRQ_GROUP4_MAP_SVH
`define IRQ_GROUP4_MAP_SVH

// Register byte offsets
`define IRQ_ENABLE_OFFSET 8'hb4
`define IRQ_STATUS_OFFSET 8'hb0
// Reset values
`define IRQ_ENABLE_RESET  32'h0000_0000
`define IRQ_STATUS_RESET  32'h0000_0000
// Field positions inside the 32-bit word
`define FLD_B_ANC_MSB     31
`define FLD_B_ANC_LSB     28
`define FLD_A_ANC_MSB     27
`define FLD_A_ANC_LSB     12
`define FLD_B_VID_MSB     11
`define FLD_B_VID_LSB     0

`endif

// ===== rtl/irq_group4_pkg.sv
package irq_group4_pkg;
  // One bit per channel event of the group
  typedef logic [31:0] word_t;
  // Register decode result
  typedef enum logic [1:0] {
    sel_none,
    sel_status,
    sel_enable
  } reg_sel_t;
endpackage

// ===== tb/irq_sink.sv
`timescale 1ns/1ps
`default_nettype none
// Processor side: latches each rise of the level line as one request
module irq_sink
(
  // Clock, reset, line and rise count
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic irq,
  output var  int   n_rise
);
  logic seen_q;
  // Edge detect; a level held high is one request, not many
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_q <= 1'b0;
      n_rise <= 0;
    end
    else
    begin
      if (irq && !seen_q)
        n_rise <= n_rise + 1;
      seen_q <= irq;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_group4_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, prd = 1'b0, irq;
  logic [7:0] addr = 8'h00;
  word_t      wdata = '0, ev = '0, rdata, st = '0, en = '0, pold = '0, lf = 32'h56;
  int         miscompares = 0, n_checks = 0, n_rise;
  // 20 MHz clock
  always #25 clk = ~clk;
  dma_channel_irq_enable_group4 DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .done_b_anc(ev[31:28]), .done_a_anc(ev[27:12]),
    .done_b_vid(ev[11:0]), .dma_irq_line_one(irq));
  irq_sink cpu (.clk(clk), .rstn(rstn), .irq(irq), .n_rise(n_rise));
  function automatic word_t lfsr(word_t v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(word_t got, word_t want);
    n_checks++;
    if (got !== want)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_irq(logic got, logic want);
    chk({31'h0, got}, {31'h0, want});
  endtask
  // One bus cycle; the previous cycle's results are checked mid-cycle, once settled
  task automatic step(logic w, logic r, logic [7:0] a, word_t d, word_t e);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    ev <= e;
    @(negedge clk);
    chk_irq(irq, |(st & en));
    chk(rdata, prd ? pold : '0);
    prd = r;
    pold = (a == 8'hb4) ? en : (a == 8'hb0) ? st : '0;
    st = (st & ~((w && a == 8'hb0) ? d : '0)) | e;
    if (w && a == 8'hb4)
      en = d;
    @(posedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog, about three times the expected run
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    step(1'b0, 1'b1, 8'hb4, '0, '0);
    step(1'b0, 1'b1, 8'hb0, '0, '0);
    $display("reset values done");
    // Walking one: masked events stay silent, own event raises the line
    for (int i = 0; i < 32; i++)
    begin
      step(1'b1, 1'b0, 8'hb4, 32'h1 << i, '0);
      step(1'b0, 1'b0, 8'h00, '0, ~(32'h1 << i));
      step(1'b0, 1'b0, 8'h00, '0, 32'h1 << i);
      step(1'b0, 1'b1, 8'hb0, '0, '0);
      step(1'b1, 1'b0, 8'hb0, 32'h1 << i, '0);
      step(1'b1, 1'b0, 8'hb0, '1, '0);
    end
    $display("walking enable done");
    step(1'b1, 1'b0, 8'h40, '1, '0);
    step(1'b0, 1'b1, 8'h40, '0, '0);
    // Random traffic; no events in read cycles, where the sample point is open
    repeat (500)
    begin
      lf = lfsr(lf);
      step(lf[0], lf[1] & ~lf[0], lf[2] ? 8'hb4 : lf[3] ? 8'hb0 : lf[15:8], lfsr(lf),
        (lf[1] & ~lf[0]) ? '0 : lf & (lf >> 7) & (lf << 3));
    end
    step(1'b0, 1'b0, 8'h00, '0, '0);
    $display("random traffic done, %0d interrupt requests", n_rise);
    tally_and_finish;
  end
endmodule
`default_nettype wire
